// ===== hw/perf_state_consts.svh
`ifndef PERF_STATE_CONSTS_SVH
`define PERF_STATE_CONSTS_SVH

// register indices on the model-specific access port
`define IDX_TARGET_CONTROL 16'h0010
`define IDX_CURRENT_STATUS 16'h0011
`define IDX_MISC_ENABLE 16'h0012

// field positions
`define MISC_XFER_EN_BIT 16
`define ID_XFER_FEATURE_BIT 7
`define STATUS_BUSY_BIT 16
`define RATIO_LSB 8
`define RATIO_MSB 15
`define VID_LSB 0
`define VID_MSB 7

// reset values
`define RESET_POINT 16'h0000
`define RESET_ENABLE 1'b0

// timing
`define CLK_PERIOD_NS 4
`define SETTLE_TIME_NS 800
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/perf_state_pkg.sv
package perf_state_pkg;
   typedef logic [15:0] op_point_t;
   typedef logic [15:0] reg_idx_t;
   typedef logic [63:0] reg_data_t;
   typedef logic [7:0] ratio_t;
   typedef logic [11:0] settle_cnt_t;
   typedef enum logic {
      xfer_idle,
      xfer_settle
   } xfer_state_e;
endpackage : perf_state_pkg

// ===== hw/perf_state_transition_ctrl.sv
`timescale 1ns/100ps
`include "perf_state_consts.svh"
// Behaviour
// - feature bit 7 of the identification word advertises transition support.
// - transitions are enabled by bit 16 of misc enable; reset clears it.
// - writing a 16-bit point to target control starts a transition.
// - a write during a transition is applied after the current one completes.
// - reading target control returns the last written target.
// - a separate status register shows the point currently in effect.
// - the 16-bit point is decoded by a model-specific mapping.
// - each transition steps discretely, without sleep or bus hold-off.
module perf_state_transition_ctrl (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // model-specific register access
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input perf_state_pkg::reg_idx_t reg_idx_in,
   input perf_state_pkg::reg_data_t reg_wdata_in,
   output perf_state_pkg::reg_data_t reg_rdata_out,
   output logic reg_rd_valid_out,
   output logic reg_fault_out,
   // identification query
   output logic [31:0] id_feature_word_out,
   // to clock generation and voltage regulation
   output perf_state_pkg::ratio_t clk_ratio_out,
   output perf_state_pkg::ratio_t volt_id_out,
   output logic xfer_busy_out
);
   import perf_state_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   perf_xfer_if xfer ();

   perf_step_engine u_engine (
      .clk_sys_in (clk_sys_in),
      .rst_b_in (rst_b_in),
      .xfer (xfer.engine),
      .clk_ratio_out (clk_ratio_out),
      .volt_id_out (volt_id_out)
   );

   ////////////////////////////////////////////////////////////////////////
   logic enable_reg, enable_next;
   op_point_t target_reg, target_next;
   logic pending_reg, pending_next;
   reg_data_t rdata_reg, rdata_next;
   logic rd_valid_reg, rd_valid_next;
   logic fault_reg, fault_next;
   logic wr_target, wr_misc, idx_known, start;

   assign wr_target = reg_wr_in && reg_idx_in == `IDX_TARGET_CONTROL;
   assign wr_misc = reg_wr_in && reg_idx_in == `IDX_MISC_ENABLE;
   assign idx_known = reg_idx_in == `IDX_TARGET_CONTROL
                   || reg_idx_in == `IDX_CURRENT_STATUS
                   || reg_idx_in == `IDX_MISC_ENABLE;
   assign start = pending_reg && enable_reg && !xfer.busy;

   always_comb begin
      enable_next = enable_reg;
      target_next = target_reg;
      pending_next = pending_reg;
      if (start) begin
         pending_next = 1'b0;
      end
      if (wr_misc) begin
         enable_next = reg_wr_in && reg_wdata_in[`MISC_XFER_EN_BIT];
      end
      if (wr_target) begin
         target_next = reg_wdata_in[15:0];
         // disabled writes stored only; a write in the start cycle stays pending
         if (enable_reg) begin
            pending_next = 1'b1;
         end
      end
      // dropping the enable discards a queued target
      if (!enable_next) begin
         pending_next = 1'b0;
      end
   end

   always_comb begin
      rdata_next = '0;
      rd_valid_next = reg_rd_in;
      fault_next = (reg_rd_in || reg_wr_in) && !idx_known;
      if (reg_rd_in) begin
         unique case (reg_idx_in)
            `IDX_TARGET_CONTROL: rdata_next[15:0] = target_reg;
            `IDX_CURRENT_STATUS: begin
               rdata_next[15:0] = xfer.current;
               rdata_next[`STATUS_BUSY_BIT] = xfer.busy;
            end
            `IDX_MISC_ENABLE: rdata_next[`MISC_XFER_EN_BIT] = enable_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         enable_reg <= `RESET_ENABLE;
         target_reg <= `RESET_POINT;
         pending_reg <= 1'b0;
      end else begin
         enable_reg <= enable_next;
         target_reg <= target_next;
         pending_reg <= pending_next;
      end
   end

   // read answers sit in their own registers so a busy engine never delays them
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_reg <= '0;
         rd_valid_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rd_valid_reg <= rd_valid_next;
         fault_reg <= fault_next;
      end
   end

   // the engine always takes the newest target, so stale queued values never run
   assign xfer.start = start;
   assign xfer.target = target_reg;

   always_comb begin
      id_feature_word_out = 32'h0000_0000;
      id_feature_word_out[`ID_XFER_FEATURE_BIT] = 1'b1;
   end

   assign reg_rdata_out = rdata_reg;
   assign reg_rd_valid_out = rd_valid_reg;
   assign reg_fault_out = fault_reg;
   assign xfer_busy_out = xfer.busy;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   chk_feature_bit_set: assert property (id_feature_word_out == 32'h0000_0080)
      else $error("feature bit not advertised");
   chk_enable_write: assert property (wr_misc |=> enable_reg == $past(reg_wdata_in[16]))
      else $error("enable bit did not follow write");
   chk_write_starts: assert property (wr_target && enable_reg && !pending_reg && !xfer.busy
      |=> xfer.start ##1 xfer.busy)
      else $error("target write did not start a transition");
   chk_queued_target: assert property (pending_reg && enable_reg && xfer.busy
      |-> ##[1:300] (xfer.start || !enable_reg))
      else $error("queued target never applied");
   chk_read_target: assert property (reg_rd_in && reg_idx_in == `IDX_TARGET_CONTROL
      |=> reg_rd_valid_out && reg_rdata_out[15:0] == $past(target_reg))
      else $error("target read returned wrong value");
   chk_status_read: assert property (reg_rd_in && reg_idx_in == `IDX_CURRENT_STATUS
      |=> reg_rdata_out[15:0] == $past(xfer.current))
      else $error("status read returned wrong point");
   chk_disabled_write: assert property (wr_target && !enable_reg && !pending_reg
      |=> !pending_reg ##1 !xfer.start)
      else $error("write started a transition while disabled");
   chk_no_start_off: assert property (!enable_reg |-> !xfer.start)
      else $error("transition started while disabled");

   // queued work and the read port, stepped out cycle by cycle
   sequence pending_idle_s;
      pending_reg && enable_reg && !xfer.busy;
   endsequence
   sequence engine_takes_s;
      xfer.start ##1 xfer.busy;
   endsequence
   sequence status_read_s;
      reg_rd_in && reg_idx_in == `IDX_CURRENT_STATUS;
   endsequence

   chk_pending_restart: assert property (pending_idle_s |-> engine_takes_s)
      else $error("queued target not handed to the engine");
   // the engine latches what it is handed, so a stale target would show here
   chk_newest_wins: assert property (xfer.start
      |=> u_engine.goal_reg == $past(target_reg))
      else $error("engine did not take the newest target");

   chk_target_capture: assert property (wr_target
      |=> target_reg == $past(reg_wdata_in[15:0]))
      else $error("target register did not take the written point");
   chk_unknown_write: assert property (reg_wr_in && !idx_known
      |=> reg_fault_out && $stable(target_reg) && $stable(enable_reg))
      else $error("unknown index write not refused");
   chk_target_kept: assert property (!wr_target |=> $stable(target_reg))
      else $error("target register changed without a write");
   chk_enable_held: assert property (!wr_misc |=> $stable(enable_reg))
      else $error("enable bit changed without a write");

   // read port: one answer per strobe, zero otherwise
   chk_valid_pulse: assert property (reg_rd_valid_out == $past(reg_rd_in))
      else $error("read valid not one cycle after the strobe");
   chk_rdata_quiet: assert property (!reg_rd_in |=> reg_rdata_out == '0)
      else $error("read data not zero outside a read");
   chk_read_zero_fill: assert property (reg_rd_in
      |=> reg_rdata_out[63:17] == '0)
      else $error("read data not zero filled");
   chk_unknown_read: assert property (reg_rd_in && !idx_known
      |=> reg_fault_out && reg_rdata_out == '0)
      else $error("unknown index read not faulted");
   chk_misc_read: assert property (reg_rd_in && reg_idx_in == `IDX_MISC_ENABLE
      |=> reg_rdata_out[`MISC_XFER_EN_BIT] == $past(enable_reg))
      else $error("enable bit read back wrong");
   chk_status_busy: assert property (status_read_s
      |=> reg_rdata_out[`STATUS_BUSY_BIT] == $past(xfer.busy))
      else $error("status busy bit wrong");
   chk_no_hold_off: assert property (xfer.busy && reg_rd_in |=> reg_rd_valid_out)
      else $error("read held off during a transition");

   chk_disable_drops: assert property (wr_misc && !reg_wdata_in[`MISC_XFER_EN_BIT]
      |=> !pending_reg)
      else $error("queued target kept after disable");
   chk_disabled_idle: assert property (!enable_reg && !xfer.busy |=> !xfer.busy)
      else $error("engine left idle while disabled");
endmodule : perf_state_transition_ctrl

// ===== hw/perf_step_engine.sv
`timescale 1ns/100ps
`include "perf_state_consts.svh"
module perf_step_engine (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // link to the control block
   perf_xfer_if.engine xfer,
   // to clock generation and voltage regulation
   output perf_state_pkg::ratio_t clk_ratio_out,
   output perf_state_pkg::ratio_t volt_id_out
);
   import perf_state_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   xfer_state_e state_reg, state_next;
   settle_cnt_t count_reg, count_next;
   op_point_t goal_reg, goal_next;
   op_point_t current_reg, current_next;
   ratio_t ratio_reg, ratio_next;
   ratio_t vid_reg, vid_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      goal_next = goal_reg;
      current_next = current_reg;
      ratio_next = ratio_reg;
      vid_next = vid_reg;
      unique case (state_reg)
         xfer_idle: begin
            if (xfer.start) begin
               goal_next = xfer.target;
               ratio_next = xfer.target[`RATIO_MSB:`RATIO_LSB];
               vid_next = xfer.target[`VID_MSB:`VID_LSB];
               count_next = settle_cnt_t'(`SETTLE_CYCLES - 1);
               state_next = xfer_settle;
            end
         end
         xfer_settle: begin
            if (count_reg == '0) begin
               current_next = goal_reg;
               state_next = xfer_idle;
            end else begin
               count_next = count_reg - 12'h001;
            end
         end
      endcase
   end

   // no stall of the rest of the core: new ratio goes out at once, status waits for settle
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= xfer_idle;
         count_reg <= '0;
         goal_reg <= `RESET_POINT;
         current_reg <= `RESET_POINT;
         ratio_reg <= ratio_t'(`RESET_POINT >> `RATIO_LSB);
         vid_reg <= ratio_t'(`RESET_POINT >> `VID_LSB);
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         goal_reg <= goal_next;
         current_reg <= current_next;
         ratio_reg <= ratio_next;
         vid_reg <= vid_next;
      end
   end

   assign xfer.busy = (state_reg == xfer_settle);
   assign xfer.current = current_reg;
   assign clk_ratio_out = ratio_reg;
   assign volt_id_out = vid_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   sequence start_idle_s;
      xfer.start && state_reg == xfer_idle;
   endsequence
   sequence settle_window_s;
      xfer.busy ##199 xfer.busy ##1 !xfer.busy;
   endsequence

   chk_settle_length: assert property (start_idle_s |=> settle_window_s)
      else $error("transition did not last the settle time");
   chk_status_follows: assert property ($fell(xfer.busy) |-> current_reg == $past(goal_reg))
      else $error("status did not take the new point");
   chk_decode_drive: assert property (xfer.busy |->
      clk_ratio_out == goal_reg[15:8] && volt_id_out == goal_reg[7:0])
      else $error("driven ratio or voltage does not match target");
endmodule : perf_step_engine

// ===== hw/perf_xfer_if.sv
`timescale 1ns/100ps
interface perf_xfer_if;
   import perf_state_pkg::*;
   logic start;
   op_point_t target;
   logic busy;
   op_point_t current;
   modport ctrl (output start, output target, input busy, input current);
   modport engine (input start, input target, output busy, output current);
endinterface : perf_xfer_if

// ===== tb/perf_state_transition_ctrl_tb.sv
`timescale 1ns/100ps
`include "perf_state_consts.svh"
module perf_state_transition_ctrl_tb;
   import perf_state_pkg::*;
   localparam reg_idx_t idx_tgt = `IDX_TARGET_CONTROL;
   localparam reg_idx_t idx_sts = `IDX_CURRENT_STATUS;
   localparam reg_idx_t idx_en = `IDX_MISC_ENABLE;
   localparam reg_data_t en_val = 64'h1 << `MISC_XFER_EN_BIT;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   reg_idx_t reg_idx_in = 16'h0000;
   reg_data_t reg_wdata_in = 64'h0;
   reg_data_t reg_rdata_out;
   logic reg_rd_valid_out, reg_fault_out, xfer_busy_out;
   logic [31:0] id_feature_word_out;
   ratio_t clk_ratio_out, volt_id_out;
   op_point_t applied;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'haa20d3f9;
   // bench model: last target, point in effect, enable
   op_point_t m_tgt = 16'h0000;
   op_point_t m_cur = 16'h0000;
   logic m_en = 1'b0;

   perf_state_transition_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_idx_in(reg_idx_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .reg_rd_valid_out(reg_rd_valid_out), .reg_fault_out(reg_fault_out),
      .id_feature_word_out(id_feature_word_out), .clk_ratio_out(clk_ratio_out),
      .volt_id_out(volt_id_out), .xfer_busy_out(xfer_busy_out));
   perf_supply_model u_supply (.clk_in(clk_sys_in), .rst_b_in(rst_b_in),
      .ratio_in(clk_ratio_out), .vid_in(volt_id_out), .busy_in(xfer_busy_out),
      .applied_out(applied));

   ////////////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task chk(input reg_data_t got, input reg_data_t exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input reg_idx_t idx, input reg_data_t d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_idx_in <= idx;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      if (idx == idx_tgt) m_tgt = d[15:0];
      if (idx == idx_en) m_en = d[`MISC_XFER_EN_BIT];
   endtask : wr

   // read answer comes exactly one cycle after the strobe
   task rd(input reg_idx_t idx, input reg_data_t exp, input logic flt);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_idx_in <= idx;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1;
      chk({62'h0, reg_fault_out, reg_rd_valid_out}, {62'h0, flt, 1'b1});
      chk(reg_rdata_out, exp);
   endtask : rd

   // settle is 200 cycles, so 400 is a safe bound
   task wait_busy(input logic v);
      int n;
      n = 0;
      while (xfer_busy_out !== v && n < 400) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      chk({63'h0, xfer_busy_out}, {63'h0, v});
   endtask : wait_busy

   task chk_pins;
      chk({48'h0, clk_ratio_out, volt_id_out}, {48'h0, m_tgt});
   endtask : chk_pins

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (6) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      #1;
      chk({32'h0, id_feature_word_out}, 64'h80);
      rd(idx_en, 64'h0, 1'b0);
      wr(idx_tgt, {$random(seed), $random(seed)});
      rd(idx_tgt, {48'h0, m_tgt}, 1'b0);
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk({63'h0, xfer_busy_out}, 64'h0);
      wr(idx_en, en_val);
      rd(idx_en, {47'h0, m_en, 16'h0000}, 1'b0);
      // a target stored while disabled must not start once enabled
      chk({63'h0, xfer_busy_out}, 64'h0);
      for (int i = 0; i < 3; i++) begin
         wr(idx_tgt, {$random(seed), $random(seed)});
         wait_busy(1'b1);
         chk_pins();
         // reads are served mid-transition, no hold-off
         rd(idx_sts, {47'h0, 1'b1, m_cur}, 1'b0);
         if (i == 1) begin
            wr(idx_tgt, {$random(seed), $random(seed)});
            wr(idx_tgt, {$random(seed), $random(seed)});
            rd(idx_tgt, {48'h0, m_tgt}, 1'b0);
            wait_busy(1'b0);
            wait_busy(1'b1);
            chk_pins();
         end
         wait_busy(1'b0);
         m_cur = m_tgt;
         rd(idx_sts, {48'h0, m_cur}, 1'b0);
         chk({48'h0, applied}, {48'h0, m_cur});
      end
      // dropping the enable throws away the queued target; the running one still ends
      wr(idx_tgt, {$random(seed), $random(seed)});
      wait_busy(1'b1);
      wr(idx_tgt, {$random(seed), $random(seed)});
      wr(idx_en, 64'h0);
      wait_busy(1'b0);
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk({63'h0, xfer_busy_out}, 64'h0);
      rd(idx_en, {47'h0, m_en, 16'h0000}, 1'b0);
      rd(idx_tgt, {48'h0, m_tgt}, 1'b0);
      rd(16'h0013, 64'h0, 1'b1);
      give_verdict();
   end
endmodule : perf_state_transition_ctrl_tb

// ===== tb/perf_supply_model.sv
`timescale 1ns/100ps
module perf_supply_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // from the transition control
   input perf_state_pkg::ratio_t ratio_in,
   input perf_state_pkg::ratio_t vid_in,
   input wire logic busy_in,
   // point the supply has settled on
   output perf_state_pkg::op_point_t applied_out
);
   import perf_state_pkg::*;
   logic busy_reg;
   // one discrete step, taken when settling ends
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_reg <= 1'b0;
         applied_out <= 16'h0000;
      end else begin
         busy_reg <= busy_in;
         if (busy_reg && !busy_in) begin
            applied_out <= {ratio_in, vid_in};
         end
      end
   end
endmodule : perf_supply_model
